// ---- design/period_timer_one_shot.sv ----
// Period-match timer with software-start one-shot mode and PWM drive
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "timer_limit_defs.svh"

module period_timer_one_shot #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  // Timer input clock pin, sampled on ref_clk
  input  wire logic                       timer_input_clock,
  // Register port
  input  wire timer_limit_pkg::reg_req_t  reg_req,
  output logic [7:0]                      reg_rdata,
  // Timer outputs
  output logic                            pwm_drive,
  output logic                            period_match_pulse,
  output logic                            run_bit
);
  import timer_limit_pkg::*;

  logic [7:0]       hardware_limit_control;
  logic [WIDTH-1:0] period_value;
  logic [WIDTH-1:0] pulse_width_value;
  logic [WIDTH-1:0] timer_count;
  logic             clk_meta;
  logic             clk_sync;
  logic             clk_prev;
  logic             edge_raw;
  logic             edge_synced;
  logic             tick;
  logic [`RUN_SYNC_STAGES-1:0] run_pipe;
  logic             run_eff;
  logic             one_shot;
  logic             match_period;
  logic             match_width;
  logic             run_set_by_sw;
  phase_t           phase;
  phase_t           next_phase;
  logic             edge_rise;
  logic             edge_fall;
  logic             count_step;
  logic             one_shot_end;
  logic             control_write;
  logic             run_write;
  logic             period_write;
  logic             width_write;
  logic             count_write;
  logic             next_run_bit;
  logic [WIDTH-1:0] next_count;
  logic             next_pwm_drive;
  logic [7:0]       status_word;
  logic [7:0]       next_rdata;

  // Mode decode used by several processes
  function automatic logic is_one_shot(input logic [7:0] ctrl);
    return ctrl[`MODE_MSB:0] == `MODE_ONE_SHOT;
  endfunction

  // Write strobe decode shared by every writable register
  function automatic logic is_write(input reg_req_t req, input logic [3:0] addr);
    return req.wr && (req.addr == addr);
  endfunction

  // One write strobe per register; unmapped addresses match none
  assign control_write = is_write(reg_req, `ADDR_LIMIT_CONTROL);
  assign run_write     = is_write(reg_req, `ADDR_RUN_CONTROL);
  assign period_write  = is_write(reg_req, `ADDR_PERIOD);
  assign width_write   = is_write(reg_req, `ADDR_PULSE_WIDTH);
  assign count_write   = is_write(reg_req, `ADDR_COUNT);

  // Mode and run start decode
  assign one_shot      = is_one_shot(hardware_limit_control);
  assign run_set_by_sw = run_write && reg_req.wdata[0];

  // Input clock pin through two flip-flops before any logic reads it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
    end else begin
      clk_meta <= timer_input_clock;
      clk_sync <= clk_meta;
    end
  end

  // Previous synchronised level; resets to the idle low of the pin, so no false edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_sync;
    end
  end

  // Rising and falling edges of the synchronised input clock
  assign edge_rise = !clk_prev && clk_sync;
  assign edge_fall = clk_prev && !clk_sync;

  // Active edge select
  assign edge_raw  = hardware_limit_control[`CLOCK_EDGE_BIT] ? edge_fall : edge_rise;

  // Optional extra register stage aligning the prescaled edge to the instruction clock
  // It costs one cycle of latency but keeps count reads coherent
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_synced <= 1'b0;
    end else begin
      edge_synced <= edge_raw;
    end
  end
  assign tick = hardware_limit_control[`PRESCALER_SYNC_BIT] ? edge_synced : edge_raw;

  // Run bit pipeline clocked by active timer input edges; read only when run sync is on
  // Stopping is immediate; only a start waits for two input edges
  // With sync off the pipe still shifts but nothing reads it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_pipe <= '0;
    end else if (edge_raw) begin
      run_pipe <= {run_pipe[`RUN_SYNC_STAGES-2:0], run_bit};
    end
  end
  assign run_eff = hardware_limit_control[`RUN_SYNC_BIT] ? (run_bit && run_pipe[`RUN_SYNC_STAGES-1])
                                                         : run_bit;

  // Equality compares: a count above the period runs on to wrap first
  assign match_period = timer_count == period_value;
  assign match_width  = timer_count == pulse_width_value;

  // A counting tick is an active input edge while the run bit is in effect
  assign count_step   = tick && run_eff;
  // The one-shot cycle ends on a counting tick at the period value
  assign one_shot_end = one_shot && count_step && match_period;

  // Limit control register; its fields steer the count, run, phase and drive processes below
  // Changing the edge select while running may give one stray count
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hardware_limit_control <= `LIMIT_CONTROL_RESET;
    end else if (control_write) begin
      hardware_limit_control <= reg_req.wdata;
    end
  end

  // Period register; all ones after reset so a free run spans full scale
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      period_value <= '1;
    end else if (period_write) begin
      period_value <= WIDTH'(reg_req.wdata);
    end
  end

  // Pulse-width compare register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_width_value <= '0;
    end else if (width_write) begin
      pulse_width_value <= WIDTH'(reg_req.wdata);
    end
  end

  // Next run bit: software sets and clears, one-shot period match clears
  // A software write in the match cycle wins over the hardware clear
  always_comb begin
    next_run_bit = run_bit;
    if (run_write) begin
      next_run_bit = reg_req.wdata[0];
    end else if (one_shot_end) begin
      next_run_bit = 1'b0;
    end
  end

  // Run bit register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_bit <= 1'b0;
    end else begin
      run_bit <= next_run_bit;
    end
  end

  // Next count: load, wrap at the period value, step, or hold when halted
  always_comb begin
    next_count = timer_count;
    if (count_write) begin
      next_count = WIDTH'(reg_req.wdata);
    end else if (count_step) begin
      if (match_period) begin
        next_count = '0;
      end else begin
        next_count = timer_count + 1'b1;
      end
    end
  end

  // Counter register
  // Halting leaves it unchanged, so a paused cycle resumes where it stood
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_count <= '0;
    end else begin
      timer_count <= next_count;
    end
  end

  // Next cycle phase; pausing keeps the phase
  always_comb begin
    next_phase = phase;
    case (phase)
      phase_idle: begin
        if (run_set_by_sw) begin
          next_phase = phase_running;
        end
      end
      phase_running: begin
        if (one_shot_end) begin
          next_phase = phase_done;
        end
      end
      phase_done: begin
        if (run_set_by_sw) begin
          next_phase = phase_running;
        end
      end
      default: next_phase = phase_idle;
    endcase
  end

  // Cycle phase register
  // Only a software start leaves the done phase
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= phase_idle;
    end else begin
      phase <= next_phase;
    end
  end

  // Next drive: on with a run start, off at width match or at the cycle end
  always_comb begin
    next_pwm_drive = pwm_drive;
    if (run_set_by_sw && !run_bit) begin
      next_pwm_drive = 1'b1;
    end else if (count_step && match_width) begin
      next_pwm_drive = 1'b0;
    end else if (one_shot_end) begin
      next_pwm_drive = 1'b0;
    end
  end

  // PWM drive register
  // While run is cleared no tick counts, so the drive is stretched
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_drive <= 1'b0;
    end else begin
      pwm_drive <= next_pwm_drive;
    end
  end

  // Period match event, one cycle after the counting tick, in every mode
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      period_match_pulse <= 1'b0;
    end else begin
      period_match_pulse <= count_step && match_period;
    end
  end

  // Status word: cycle phase and drive level
  // The phase tells software whether a new start is armed
  assign status_word = {5'h00, phase, pwm_drive};

  // Read data selection; unmapped addresses and idle cycles read as zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_req.rd) begin
      case (reg_req.addr)
        `ADDR_LIMIT_CONTROL: next_rdata = hardware_limit_control;
        `ADDR_RUN_CONTROL:   next_rdata = {7'h00, run_bit};
        `ADDR_PERIOD:        next_rdata = 8'(period_value);
        `ADDR_PULSE_WIDTH:   next_rdata = 8'(pulse_width_value);
        `ADDR_COUNT:         next_rdata = 8'(timer_count);
        `ADDR_STATUS:        next_rdata = status_word;
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ---- design/timer_limit_defs.svh ----
// Constants of the one-shot period timer and its limit control register
`ifndef TIMER_LIMIT_DEFS_SVH
`define TIMER_LIMIT_DEFS_SVH

// Register addresses
`define ADDR_LIMIT_CONTROL 4'h0
`define ADDR_RUN_CONTROL   4'h1
`define ADDR_PERIOD        4'h2
`define ADDR_PULSE_WIDTH   4'h3
`define ADDR_COUNT         4'h4
`define ADDR_STATUS        4'h5

// Field positions of the limit control register
`define PRESCALER_SYNC_BIT 7
`define CLOCK_EDGE_BIT     6
`define RUN_SYNC_BIT       5
`define MODE_MSB           4

// Reset values and encodings
`define LIMIT_CONTROL_RESET 8'h00
`define MODE_ONE_SHOT       5'h08
`define RUN_SYNC_STAGES     2

`endif

// ---- design/timer_limit_pkg.sv ----
// Types shared by the one-shot period timer
package timer_limit_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef enum logic [1:0] {
    phase_idle    = 2'b00,
    phase_running = 2'b01,
    phase_done    = 2'b10
  } phase_t;

endpackage

// ---- dv/period_timer_one_shot_monitor.sv ----
// Port-level checks of the one-shot period timer
`timescale 1ns/100ps
`include "timer_limit_defs.svh"
module period_timer_one_shot_monitor #(parameter int WIDTH = 8) (
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      reset_n,
  // Watched inputs and outputs
  input wire logic                      timer_input_clock,
  input wire timer_limit_pkg::reg_req_t reg_req,
  input wire logic [7:0]                reg_rdata,
  input wire logic                      pwm_drive,
  input wire logic                      period_match_pulse,
  input wire logic                      run_bit
);
  import timer_limit_pkg::*;
  logic [4:0] mode;
  logic       run_wr;
  logic       run_set;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Software writes to the run control register
  assign run_wr  = reg_req.wr && reg_req.addr == `ADDR_RUN_CONTROL;
  assign run_set = run_wr && reg_req.wdata[0];
  // Shadow of the mode field
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      mode <= 5'h00;
    else if (reg_req.wr && reg_req.addr == `ADDR_LIMIT_CONTROL)
      mode <= reg_req.wdata[4:0];
  end
  a_start_drive: assert property (run_set && !run_bit |=> run_bit && pwm_drive)
    else $error("run start without drive");
  a_oneshot_stop: assert property (period_match_pulse && mode == `MODE_ONE_SHOT && !$past(run_wr) |-> !run_bit)
    else $error("run left set after match");
  a_no_restart: assert property ($rose(run_bit) |-> $past(run_set))
    else $error("run set without software");
  a_drive_gated: assert property ($rose(pwm_drive) |-> $rose(run_bit))
    else $error("drive rose without start");
  a_pause_hold: assert property ($past(pwm_drive) && !$past(run_bit) |-> pwm_drive)
    else $error("drive dropped while paused");
  a_match_once: assert property (period_match_pulse |=> !period_match_pulse)
    else $error("match pulse too long");
  a_halt_quiet: assert property (!$past(run_bit) && !$past(run_bit, 2) |-> !period_match_pulse)
    else $error("match while halted");
  a_idle_rdata: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
endmodule
bind period_timer_one_shot period_timer_one_shot_monitor #(.WIDTH(WIDTH)) period_timer_one_shot_monitor_i (
  .ref_clk(ref_clk), .reset_n(reset_n), .timer_input_clock(timer_input_clock), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .pwm_drive(pwm_drive), .period_match_pulse(period_match_pulse), .run_bit(run_bit));

// ---- dv/testbench.sv ----
// Self-checking bench of the one-shot period timer
`timescale 1ns/100ps
`include "timer_limit_defs.svh"
module testbench;
  import timer_limit_pkg::*;
  logic       ref_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       timer_input_clock = 1'b0;
  reg_req_t   reg_req = '0;
  logic [7:0] reg_rdata;
  logic       pwm_drive;
  logic       period_match_pulse;
  logic       run_bit;
  logic [7:0] got, per, cnt;
  logic [7:0] ctl [4] = '{8'h08, 8'h48, 8'ha8, 8'he8};
  int         fails = 0;
  int         checked = 0;
  int         tdiv = 0;
  int         n;
  int         pm = 0;
  always #2 ref_clk = ~ref_clk;
  // Timer input clock at one sixth of the core rate
  always @(posedge ref_clk) begin
    tdiv <= (tdiv == 2) ? 0 : tdiv + 1;
    if (tdiv == 2) timer_input_clock <= ~timer_input_clock;
  end
  // Counts period match pulses seen on the output
  always @(posedge ref_clk) begin
    if (period_match_pulse === 1'b1) pm <= pm + 1;
  end
  period_timer_one_shot #(.WIDTH(8)) period_timer_one_shot_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .timer_input_clock(timer_input_clock), .reg_req(reg_req), .reg_rdata(reg_rdata), .pwm_drive(pwm_drive),
    .period_match_pulse(period_match_pulse), .run_bit(run_bit));
  task chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    reg_req <= '0;
    @(posedge ref_clk);
  endtask
  task rd(input logic [3:0] a);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    reg_req <= '0;
    #1 got = reg_rdata;
    @(posedge ref_clk);
  endtask
  task rdc(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(got, e);
  endtask
  task final_report;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    #100000;
    fails++;
    final_report;
  end
  // Reset values, then one one-shot cycle for each control setting
  initial begin
    n = $urandom(39682);
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rdc(`ADDR_LIMIT_CONTROL, `LIMIT_CONTROL_RESET);
    rdc(`ADDR_PERIOD, 8'hff);
    rdc(`ADDR_COUNT, 8'h00);
    rdc(4'hc, 8'h00);
    foreach (ctl[i]) begin
      per = 8'h04 + 8'($urandom % 12);
      wr(`ADDR_LIMIT_CONTROL, ctl[i]);
      rdc(`ADDR_LIMIT_CONTROL, ctl[i]);
      wr(`ADDR_PERIOD, per);
      wr(`ADDR_PULSE_WIDTH, (i == 0) ? per : per >> 1);
      wr(`ADDR_RUN_CONTROL, 8'h01);
      chk({6'h0, run_bit, pwm_drive}, 8'h03);
      n = 0;
      if (i == 0) begin
        repeat (5) @(posedge ref_clk);
        wr(`ADDR_RUN_CONTROL, 8'h00);
        repeat (20) @(posedge ref_clk);
        rd(`ADDR_COUNT);
        cnt = got;
        repeat (30) @(posedge ref_clk);
        rdc(`ADDR_COUNT, cnt);
        chk({7'h0, pwm_drive}, 8'h01);
        wr(`ADDR_RUN_CONTROL, 8'h01);
      end
      while (run_bit === 1'b1 && n < 400) begin
        @(posedge ref_clk);
        n++;
      end
      chk({6'h0, n >= (int'(per) - ((i == 0) ? int'(cnt) : 0)) * 6 - 6, n < 300}, 8'h03);
      chk({6'h0, run_bit, pwm_drive}, 8'h00);
      rdc(`ADDR_COUNT, 8'h00);
      repeat (40) @(posedge ref_clk);
      chk({7'h0, run_bit}, 8'h00);
      rdc(`ADDR_STATUS, {5'h00, phase_done, 1'b0});
      chk(8'(pm), 8'(i + 1));
    end
    wr(`ADDR_STATUS, 8'hff);
    rdc(`ADDR_STATUS, {5'h00, phase_done, 1'b0});
    final_report;
  end
endmodule
